// ==== logic/icfm_pkg.sv ====
// Purpose: shared constants and types for the input clock frequency monitor
// Assumes: 100 MHz reference clock, AXI4-Lite register access
// Notes: register offsets are indices; the byte address is four times the index
package icfm_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ = 100; // reference clock rate
    localparam int GATE_NS = 1000; // one measurement gate, 1 us
    localparam int GATE_CYC = (GATE_NS * CLK_MHZ + 999) / 1000; // gate length in cycles
    localparam int WIN0_US = 40; // stability window code 00
    localparam int WIN1_US = 80; // stability window code 01
    localparam int WIN2_US = 320; // stability window code 10
    localparam int WIN3_US = 1280; // stability window code 11, 1.28 ms
    localparam int GATE_US = GATE_NS / 1000; // gate length in us

    // ************************************************************
    // register indices
    // ************************************************************
    localparam logic [7:0] IDX_CTL1 = 8'h5b; // dual_control_one
    localparam logic [7:0] IDX_CTL2 = 8'h5c; // dual_link_control_two
    localparam logic [7:0] IDX_LOW = 8'h5d; // low_freq_limit_and_phy_policy
    localparam logic [7:0] IDX_HIGH = 8'h5e; // high_freq_limit
    localparam logic [7:0] IDX_FREQ = 8'h5f; // measured_input_frequency
    localparam logic [7:0] IDX_IRQ_STAT = 8'h70; // event status, write one to clear
    localparam logic [7:0] IDX_IRQ_MASK = 8'h71; // event mask

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RST_CTL1 = 8'h20; // pll reset on change set
    localparam logic [7:0] RST_CTL2 = 8'h02; // hysteresis 2 MHz
    localparam logic [7:0] RST_LOW = 8'h06; // low limit 6 MHz
    localparam logic [7:0] RST_HIGH = 8'h44; // high limit as printed
    localparam logic [7:0] RST_FREQ = 8'h00; // no valid signal
    localparam logic [2:0] RST_IRQ = 3'h0; // events clear and masked

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CTL1_SWAP_BIT = 6; // link swap state
    localparam int CTL1_PLLRST_BIT = 5; // pll_reset_on_change
    localparam int CTL1_SRC_BIT = 4; // measure_source_sel
    localparam int EV_SETTLED = 0; // settled rose
    localparam int EV_CHANGE = 1; // frequency captured
    localparam int EV_LOST = 2; // measured frequency fell to zero

    // dual_link_control_two layout
    typedef struct packed {
        logic disable_swap; // stop auto swap correction
        logic force_link_rdy; // link ready override
        logic override_clock_present; // clock valid override
        logic [1:0] stability_window_sel; // settle window code
        logic [2:0] measure_hysteresis_mhz; // capture hysteresis
    } icfm_ctl2_t;

    // low limit register layout
    typedef struct packed {
        logic rsvd; // reads zero
        logic phy_keep_on_power; // skip phy reset while cable power
        logic [5:0] min_freq_limit; // low limit in MHz
    } icfm_low_t;

    // status outputs toward the link side
    typedef struct packed {
        logic clk_valid; // input clock usable
        logic link_ready; // link ready indication
        logic swap_state; // current swap state
    } icfm_stat_t;

endpackage

// ==== logic/icfm_top.sv ====
// Purpose: input clock frequency monitor with AXI4-Lite registers
// Assumes: link clocks are asynchronous and slower than half of REF_CLK
// Notes: frequency is the edge count of the selected clock over a 1 us gate
//
// What this block does
// - swap-disable stops auto swap, allows software writes
// - link-ready override forces link ready
// - clock override forces valid clock indication
// - stable only after selected window within band
// - capture only when difference exceeds hysteresis or the count falls to zero
// - phy reset on change, skip under policy+power
// - six-bit low limit judges too low
// - seven-bit high limit is upper threshold
// - frequency register reads MHz, zero means none
// - read-only settled flag shows detector stability
// - pll reset on change when enabled
// - source select: raw clock or pll clock
// - swap bit shows state, writable only disabled
`timescale 1ns/10ps
module icfm_top #(
    parameter int STAB_W = 11 // width of the stability counter in gates
) (
    input wire logic REF_CLK, // reference clock, 100 MHz
    input wire logic NRST, // asynchronous reset, active low
    input wire logic LINK_CLK, // raw input link clock, asynchronous
    input wire logic PLL_CLK, // input pll output clock, asynchronous
    input wire logic CABLE_PWR_DET, // cable power detect pin
    input wire logic BACK_LINK_DET, // back channel link detected
    input wire logic SWAP_DETECTED, // auto detector sees swapped links
    input wire logic [11:0] S_AXI_AWADDR, // write address
    input wire logic S_AXI_AWVALID, // write address valid
    output logic S_AXI_AWREADY, // write address ready
    input wire logic [31:0] S_AXI_WDATA, // write data
    input wire logic [3:0] S_AXI_WSTRB, // write byte strobes
    input wire logic S_AXI_WVALID, // write data valid
    output logic S_AXI_WREADY, // write data ready
    output logic [1:0] S_AXI_BRESP, // write response
    output logic S_AXI_BVALID, // write response valid
    input wire logic S_AXI_BREADY, // write response ready
    input wire logic [11:0] S_AXI_ARADDR, // read address
    input wire logic S_AXI_ARVALID, // read address valid
    output logic S_AXI_ARREADY, // read address ready
    output logic [31:0] S_AXI_RDATA, // read data
    output logic [1:0] S_AXI_RRESP, // read response
    output logic S_AXI_RVALID, // read data valid
    input wire logic S_AXI_RREADY, // read data ready
    output icfm_pkg::icfm_stat_t STATUS, // valid, link ready, swap state
    output logic FREQ_SETTLED, // freq_settled_flag
    output logic PHY_RESET, // one-cycle phy reset pulse
    output logic PLL_RESET, // one-cycle link pll reset pulse
    output logic IRQ // level interrupt
);
    import icfm_pkg::*;

    localparam int WIN0_G = WIN0_US / GATE_US; // window lengths in gates
    localparam int WIN1_G = WIN1_US / GATE_US;
    localparam int WIN2_G = WIN2_US / GATE_US;
    localparam int WIN3_G = WIN3_US / GATE_US;

    // ************************************************************
    // elaboration checks
    // ************************************************************
    if (GATE_CYC < 2 || GATE_CYC > 255) begin : g_bad_gate
        $error("gate length out of range");
    end
    if ((2 ** STAB_W) <= WIN3_G) begin : g_bad_stab
        $error("STAB_W too small for longest window");
    end

    // ************************************************************
    // declarations
    // ************************************************************
    logic [7:0] ctl1; // dual_control_one
    icfm_ctl2_t ctl2; // dual_link_control_two
    icfm_low_t low; // low limit and phy policy
    logic [6:0] max_freq_limit; // high limit
    logic [7:0] measured_freq_mhz; // current captured frequency
    logic [2:0] irq_stat; // sticky events
    logic [2:0] irq_mask; // event enables
    logic [2:0] lclk_sync; // raw clock synchroniser and edge stage
    logic [2:0] pclk_sync; // pll clock synchroniser and edge stage
    logic [1:0] pwr_sync; // cable power synchroniser
    logic [1:0] bld_sync; // back link synchroniser
    logic [1:0] swd_sync; // swap detect synchroniser
    logic [7:0] gate_cnt; // position in the gate
    logic [7:0] edge_cnt; // edges seen in the gate
    logic [STAB_W-1:0] stab_cnt; // gates since last capture
    logic src_prev; // source select last cycle
    logic settled_prev; // settled last cycle
    logic sel_edge; // rising edge of selected clock
    logic gate_done; // last cycle of gate
    logic [7:0] next_meas; // gate result
    logic [7:0] diff; // distance from current value
    logic freq_change; // capture this cycle
    logic mode_change; // source select changed
    logic [STAB_W-1:0] win_gates; // selected window
    logic settled; // stable for window
    logic in_range; // between limits
    logic [2:0] ev_set; // events this cycle
    logic aw_held; // write address latched
    logic w_held; // write data latched
    logic [7:0] aw_idx; // latched write index
    logic [31:0] w_data; // latched write data
    logic w_lane0; // byte lane 0 enabled
    logic wr_fire; // write performed
    logic wr_hit; // write index mapped
    logic [7:0] rd_val; // read mux result
    logic rd_hit; // read index mapped
    logic clk_ok; // registered clock valid
    logic link_up; // registered link ready

    // ************************************************************
    // input synchronisers
    // ************************************************************
    // two flops before use, third flop only for clock edge detect
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            lclk_sync <= 3'h0;
            pclk_sync <= 3'h0;
            pwr_sync <= 2'h0;
            bld_sync <= 2'h0;
            swd_sync <= 2'h0;
        end else begin
            lclk_sync <= {lclk_sync[1:0], LINK_CLK};
            pclk_sync <= {pclk_sync[1:0], PLL_CLK};
            pwr_sync <= {pwr_sync[0], CABLE_PWR_DET};
            bld_sync <= {bld_sync[0], BACK_LINK_DET};
            swd_sync <= {swd_sync[0], SWAP_DETECTED};
        end
    end

    // ************************************************************
    // frequency measurement
    // ************************************************************
    // pick the detector input from the synchronised stages
    always_comb begin
        if (ctl1[CTL1_SRC_BIT]) begin
            sel_edge = pclk_sync[1] & ~pclk_sync[2];
        end else begin
            sel_edge = lclk_sync[1] & ~lclk_sync[2];
        end
    end

    assign gate_done = (gate_cnt == 8'(GATE_CYC - 1));

    // gate timer
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            gate_cnt <= 8'h00;
        end else if (gate_done || mode_change) begin
            gate_cnt <= 8'h00;
        end else begin
            gate_cnt <= gate_cnt + 8'h01;
        end
    end

    // saturating edge count and hysteresis compare
    always_comb begin
        if (sel_edge && edge_cnt != 8'hff) begin
            next_meas = edge_cnt + 8'h01;
        end else begin
            next_meas = edge_cnt;
        end
        if (next_meas > measured_freq_mhz) begin
            diff = next_meas - measured_freq_mhz;
        end else begin
            diff = measured_freq_mhz - next_meas;
        end
        // zero always captured so a lost clock reads as none
        freq_change = gate_done && (diff > {5'h00, ctl2.measure_hysteresis_mhz}
            || (next_meas == 8'h00 && measured_freq_mhz != 8'h00));
    end

    // edge counter restarts each gate
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            edge_cnt <= 8'h00;
        end else if (gate_done || mode_change) begin
            edge_cnt <= 8'h00;
        end else begin
            edge_cnt <= next_meas;
        end
    end

    // captured value, held within the hysteresis band
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            measured_freq_mhz <= RST_FREQ;
        end else if (freq_change) begin
            measured_freq_mhz <= next_meas;
        end
    end

    // ************************************************************
    // stability and validity
    // ************************************************************
    always_comb begin
        unique case (ctl2.stability_window_sel)
            2'b00: win_gates = STAB_W'(WIN0_G);
            2'b01: win_gates = STAB_W'(WIN1_G);
            2'b10: win_gates = STAB_W'(WIN2_G);
            2'b11: win_gates = STAB_W'(WIN3_G);
        endcase
    end

    // gates since last capture, saturating
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            stab_cnt <= '0;
        end else if (freq_change || mode_change) begin
            stab_cnt <= '0;
        end else if (gate_done && stab_cnt != '1) begin
            stab_cnt <= stab_cnt + STAB_W'(1);
        end
    end

    assign settled = (measured_freq_mhz != 8'h00) && (stab_cnt >= win_gates);
    assign in_range = (measured_freq_mhz >= {2'h0, low.min_freq_limit})
        && (measured_freq_mhz <= {1'b0, max_freq_limit});

    // status outputs registered
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            clk_ok <= 1'b0;
            link_up <= 1'b0;
            FREQ_SETTLED <= 1'b0;
        end else begin
            clk_ok <= ctl2.override_clock_present || (settled && in_range);
            link_up <= ctl2.force_link_rdy || bld_sync[1];
            FREQ_SETTLED <= settled;
        end
    end
    // one driver for the whole struct, members gathered here
    assign STATUS = {clk_ok, link_up, ctl1[CTL1_SWAP_BIT]};

    // ************************************************************
    // phy and pll reset pulses
    // ************************************************************
    assign mode_change = src_prev != ctl1[CTL1_SRC_BIT];

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            src_prev <= 1'b0;
            PHY_RESET <= 1'b0;
            PLL_RESET <= 1'b0;
        end else begin
            src_prev <= ctl1[CTL1_SRC_BIT];
            PHY_RESET <= (freq_change || mode_change) && !(low.phy_keep_on_power && pwr_sync[1]);
            PLL_RESET <= freq_change && ctl1[CTL1_PLLRST_BIT];
        end
    end

    // ************************************************************
    // interrupts
    // ************************************************************
    always_comb begin
        ev_set = 3'h0;
        ev_set[EV_SETTLED] = settled && !settled_prev;
        ev_set[EV_CHANGE] = freq_change;
        ev_set[EV_LOST] = freq_change && next_meas == 8'h00;
    end

    // sticky status, a new event wins over a clear
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            settled_prev <= 1'b0;
            irq_stat <= RST_IRQ;
            IRQ <= 1'b0;
        end else begin
            settled_prev <= settled;
            if (wr_fire && w_lane0 && aw_idx == IDX_IRQ_STAT) begin
                irq_stat <= (irq_stat & ~w_data[2:0]) | ev_set;
            end else begin
                irq_stat <= irq_stat | ev_set;
            end
            IRQ <= |(irq_stat & irq_mask);
        end
    end

    // ************************************************************
    // axi4-lite write channel
    // ************************************************************
    assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
    assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
    assign wr_fire = aw_held && w_held && !S_AXI_BVALID;
    assign wr_hit = aw_idx inside {IDX_CTL1, IDX_CTL2, IDX_LOW, IDX_HIGH, IDX_FREQ, IDX_IRQ_STAT, IDX_IRQ_MASK};

    // address and data taken in either order, answer after both
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_idx <= 8'h00;
            w_data <= 32'h0;
            w_lane0 <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= 2'h0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held <= 1'b1;
                aw_idx <= S_AXI_AWADDR[9:2];
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_lane0 <= S_AXI_WSTRB[0]; // lane 0 off means the write does nothing
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_hit ? 2'h0 : 2'h2; // unmapped gives slverr
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // ************************************************************
    // register file
    // ************************************************************
    // lane 0 carries all data; other lanes ignored
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            ctl1 <= RST_CTL1;
            ctl2 <= RST_CTL2;
            low <= RST_LOW;
            max_freq_limit <= RST_HIGH[6:0];
            irq_mask <= RST_IRQ;
        end else begin
            if (wr_fire && w_lane0) begin
                unique case (aw_idx)
                    IDX_CTL2: ctl2 <= w_data[7:0];
                    IDX_LOW: low <= {1'b0, w_data[6:0]};
                    IDX_HIGH: max_freq_limit <= w_data[6:0];
                    IDX_IRQ_MASK: irq_mask <= w_data[2:0];
                    default: ;
                endcase
            end
            if (wr_fire && w_lane0 && aw_idx == IDX_CTL1) begin
                ctl1[CTL1_PLLRST_BIT] <= w_data[CTL1_PLLRST_BIT];
                ctl1[CTL1_SRC_BIT] <= w_data[CTL1_SRC_BIT];
            end
            // swap bit follows the detector unless correction disabled
            if (!ctl2.disable_swap) begin
                ctl1[CTL1_SWAP_BIT] <= swd_sync[1];
            end else if (wr_fire && w_lane0 && aw_idx == IDX_CTL1) begin
                ctl1[CTL1_SWAP_BIT] <= w_data[CTL1_SWAP_BIT];
            end
        end
    end

    // ************************************************************
    // axi4-lite read channel
    // ************************************************************
    always_comb begin
        rd_hit = 1'b1;
        unique case (S_AXI_ARADDR[9:2])
            IDX_CTL1: rd_val = {1'b0, ctl1[6:4], 4'h0};
            IDX_CTL2: rd_val = ctl2;
            IDX_LOW: rd_val = low;
            IDX_HIGH: rd_val = {1'b0, max_freq_limit};
            IDX_FREQ: rd_val = measured_freq_mhz;
            IDX_IRQ_STAT: rd_val = {5'h00, irq_stat};
            IDX_IRQ_MASK: rd_val = {5'h00, irq_mask};
            default: begin
                rd_val = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    assign S_AXI_ARREADY = !S_AXI_RVALID;

    // one read under way, answer the cycle after acceptance
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0;
            S_AXI_RRESP <= 2'h0;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= {24'h0, rd_val};
            S_AXI_RRESP <= rd_hit ? 2'h0 : 2'h2;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);

    a_swap_auto_follow: assert property (!ctl2.disable_swap |=> STATUS.swap_state == $past(swd_sync[1]))
        else $error("swap state not following detector");
    a_link_rdy_force: assert property (ctl2.force_link_rdy |=> STATUS.link_ready)
        else $error("link ready not forced");
    a_clk_force_valid: assert property (ctl2.override_clock_present |=> STATUS.clk_valid)
        else $error("clock valid not forced");
    a_settle_restart: assert property (freq_change |=> !settled)
        else $error("settled right after capture");
    a_hyst_hold: assert property (gate_done && !freq_change |=> $stable(measured_freq_mhz))
        else $error("frequency changed inside hysteresis");
    a_phy_skip_power: assert property (low.phy_keep_on_power && pwr_sync[1] |=> !PHY_RESET)
        else $error("phy reset while power asserted");
    a_low_limit_chk: assert property (!ctl2.override_clock_present && measured_freq_mhz < {2'h0, low.min_freq_limit}
        |=> !STATUS.clk_valid)
        else $error("valid below low limit");
    a_high_limit_chk: assert property (!ctl2.override_clock_present && measured_freq_mhz > {1'b0, max_freq_limit}
        |=> !STATUS.clk_valid)
        else $error("valid above high limit");
    a_zero_not_settled: assert property (measured_freq_mhz == 8'h00 |=> !FREQ_SETTLED)
        else $error("settled with no signal");
    a_pll_reset_pulse: assert property (freq_change && ctl1[CTL1_PLLRST_BIT] |=> PLL_RESET ##1 !PLL_RESET)
        else $error("pll reset pulse missing");

endmodule

// ==== verification/icfm_src.sv ====
// Purpose: video source model driving the raw and pll link clocks
// Assumes: clocks stand low while the source is off
// Notes: periods in ns
`timescale 1ns/10ps
module icfm_src #(
    parameter int LINK_NS = 160, // raw clock period
    parameter int PLL_NS = 80 // pll clock period
) (
    input wire logic en, // source active
    output logic link_clk, // raw link clock
    output logic pll_clk // pll output clock
);
    initial link_clk = 1'b0;
    initial pll_clk = 1'b0;
    // toggle only while active, park low otherwise
    always #(LINK_NS / 2) link_clk = en ? ~link_clk : 1'b0;
    always #(PLL_NS / 2) pll_clk = en ? ~pll_clk : 1'b0;
endmodule

// ==== verification/icfm_top_test.sv ====
// Purpose: self-checking bench for the clock frequency monitor
// Assumes: source model at 160 ns raw, 80 ns pll
// Notes: random limits come from an lfsr seeded at 78
`timescale 1ns/10ps
module icfm_top_test;
    import icfm_pkg::*;
    logic clk = 0, nrst = 0, en = 0, pwr = 0, blk = 0, swp = 0, lc, pc; // stimulus
    logic [11:0] awa = 0, ara = 0; // addresses
    logic [31:0] wd = 0, rdt, d; // data
    logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, awr, wr_r, bv, arr, rv, irq, stl, phy, pll;
    logic [1:0] br, rr, r; // responses
    icfm_stat_t st; // status struct
    logic [7:0] s = 8'h4e; // lfsr state
    logic [3:0] stb = 4'hf; // write strobes
    int err_total = 0, num_checks = 0, cyc = 0, lp = 0, pll_n = 0, phy_n = 0, t0, a, b;
    always #5 clk = ~clk; // 100 MHz
    icfm_src icfm_src_i (.en(en), .link_clk(lc), .pll_clk(pc));
    icfm_top icfm_top_i (.REF_CLK(clk), .NRST(nrst), .LINK_CLK(lc), .PLL_CLK(pc), .CABLE_PWR_DET(pwr),
        .BACK_LINK_DET(blk), .SWAP_DETECTED(swp), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(stb), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wr_r), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdt),
        .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .STATUS(st),
        .FREQ_SETTLED(stl), .PHY_RESET(phy), .PLL_RESET(pll), .IRQ(irq));
    // pulse counters and time of last pll reset
    always @(posedge clk) begin
        cyc++;
        if (pll === 1'b1) begin
            pll_n++;
            lp = cyc;
        end
        if (phy === 1'b1) phy_n++;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    // measured MHz may read one above the exact rate
    function automatic logic near(input logic [31:0] v, input int ns);
        return v === 1000 / ns || v === 1000 / ns + 1;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // write: release each channel at its own handshake edge
    task automatic wr(input logic [11:0] ad, input logic [7:0] v);
        logic ha, hw, hb;
        hb = 0;
        awa <= ad;
        wd <= {24'h0, v};
        awv <= 1;
        wv <= 1;
        bry <= 1;
        while (!hb) begin
            @(negedge clk);
            ha = awv & awr;
            hw = wv & wr_r;
            hb = bv;
            @(posedge clk);
            if (ha) awv <= 0;
            if (hw) wv <= 0;
            if (hb) bry <= 0;
        end
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] ad, output logic [31:0] v, output logic [1:0] rs);
        logic ha, hr;
        hr = 0;
        ara <= ad;
        arv <= 1;
        rry <= 1;
        while (!hr) begin
            @(negedge clk);
            ha = arv & arr;
            hr = rv;
            v = rdt;
            rs = rr;
            @(posedge clk);
            if (ha) arv <= 0;
            if (hr) rry <= 0;
        end
        @(posedge clk);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
        rd(12'h170, d, r); chk("ctl2", d, 32'h02);
        rd(12'h174, d, r); chk("low", d, 32'h06);
        rd(12'h16c, d, r); chk("ctl1", d, 32'h20);
        rd(12'h200, d, r); chk("unmapped", r, 2'b10);
        wr(12'h200, 8'h01); chk("bresp", br, 2'b10);
        for (int i = 0; i < 3; i++) begin
            s = lfsr(s);
            wr(12'h178, s);
            rd(12'h178, d, r); chk("high", d, {25'h0, s[6:0]});
        end
        // lane 0 strobe off: the write must leave the limit alone
        stb <= 4'h0;
        wr(12'h178, 8'h11);
        stb <= 4'hf;
        rd(12'h178, d, r); chk("strobe", d, {25'h0, s[6:0]});
        wr(12'h178, 8'h44);
        wr(12'h17c, 8'h55);
        chk("bresp", br, 2'b00);
        rd(12'h17c, d, r); chk("freq", d, 32'h00);
        wr(12'h1c4, 8'h01);
        // zero hysteresis first so a partial first gate cannot stick
        wr(12'h170, 8'h08);
        en <= 1;
        repeat (300) @(posedge clk);
        wr(12'h170, 8'h0a);
        repeat (20000) if (stl !== 1'b1) @(posedge clk);
        t0 = cyc - lp;
        chk("window", t0 >= 7990 && t0 <= 8200, 1);
        chk("settled", stl, 1);
        rd(12'h17c, d, r); chk("freq", near(d, 160), 1);
        chk("valid", st.clk_valid, 1);
        chk("pll", pll_n > 0 && phy_n > 0, 1);
        chk("irq", irq, 1);
        wr(12'h1c0, 8'h01);
        repeat (3) @(posedge clk);
        chk("irq", irq, 0);
        wr(12'h174, 8'h08);
        repeat (4) @(posedge clk);
        chk("valid", st.clk_valid, 0);
        wr(12'h174, 8'h00);
        wr(12'h178, 8'h05);
        repeat (4) @(posedge clk);
        chk("valid", st.clk_valid, 0);
        wr(12'h170, 8'h2a);
        repeat (4) @(posedge clk);
        chk("valid", st.clk_valid, 1);
        chk("ready", st.link_ready, 0);
        wr(12'h170, 8'h6a);
        swp <= 1;
        repeat (6) @(posedge clk);
        chk("ready", st.link_ready, 1);
        wr(12'h16c, 8'h20);
        chk("swap", st.swap_state, 1);
        wr(12'h170, 8'hea);
        wr(12'h16c, 8'h20);
        chk("swap", st.swap_state, 0);
        wr(12'h16c, 8'h30);
        repeat (500) @(posedge clk);
        rd(12'h17c, d, r); chk("freq", near(d, 80), 1);
        wr(12'h174, 8'h46);
        pwr <= 1;
        repeat (4) @(posedge clk);
        a = pll_n;
        b = phy_n;
        en <= 0;
        repeat (400) @(posedge clk);
        rd(12'h17c, d, r); chk("freq", d, 32'h00);
        chk("pll", pll_n > a, 1);
        chk("phy", phy_n, b);
        chk("settled", stl, 0);
        rd(12'h1c0, d, r); chk("stat", d, 32'h06);
        conclude();
    end
    initial begin
        #300000;
        err_total++;
        conclude();
    end
endmodule
